/* rtl/main_clock_select_prescale.sv */
// main clock source select, switch guard, prescaler and clock requests
// assumes oscillator clocks arrive as sampled levels; outputs are clock enables
//
// Overview of operation
// - any requested source or clock is switched on automatically by hardware, except the crystal while its enable is clear
// - each request is routed to the source that serves that peripheral
// - peripheral clock is main clock divided 1x to 64x, twelve settings
// - cpu clock feeds cpu, sram, nvm; peripheral clock feeds other peripherals
// - async clocks requested only while their peripheral is enabled
// - control timer source frozen while enabled; counter source change when disabled
// - main source chosen by select field of control register a
// - oscillators with no user and no request are switched off
// - run-in-standby keeps an oscillator running except in power down
// - main clock runs in active and idle; in standby only if needed
// - power down stops main clock only after nvm operations finish
// - switch to external source only after enough edges seen
// - stuck external switch blocks further source changes until reset
// - switch pending flag set while a source switch is in progress
// - per-oscillator flags report each source running and stable
// - source and prescaler writes take effect only through timed protection
// - after reset main clock from fast oscillator, prescaler divides by six
// - fast oscillator frequency after reset chosen by fuse select bits
// - crystal acts as source only after software sets its enable
// - protected write accepted only within four instructions after the key
// - external pin clock counted ready two cycles after first request
module main_clock_select_prescale (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [7:0] protect_key_wdata,
  input  wire logic       protect_key_we,
  input  wire logic       instr_retired,
  input  wire logic       ctrl_a_we,
  input  wire logic [1:0] ctrl_a_wdata,
  input  wire logic       ctrl_b_we,
  input  wire logic [4:0] ctrl_b_wdata,
  input  wire logic       crystal_32k_enable,
  input  wire logic [3:0] run_in_standby,
  input  wire logic [1:0] fast_osc_freq_select,
  input  wire logic [1:0] sleep_mode,
  input  wire logic       nvm_busy,
  input  wire logic       periph_main_req,
  input  wire logic       rtc_enabled,
  input  wire logic       rtc_src_crystal,
  input  wire logic       wdt_enabled,
  input  wire logic       bod_sampled_enabled,
  input  wire logic       control_timer_enabled,
  input  wire logic [1:0] control_timer_src,
  input  wire logic       ext_pin_clock,
  input  wire logic       crystal_32k_clock,
  input  wire logic       crystal_32k_ready,
  input  wire logic       fast_osc_ready,
  input  wire logic       slow_osc_ready,
  output logic      [1:0] main_source_select,
  output logic      [4:0] main_clock_control_b,
  output logic      [3:0] osc_enable,
  output logic            source_switch_pending,
  output logic            ext_pin_clock_stable,
  output logic            crystal_32k_stable,
  output logic            fast_osc_stable,
  output logic            slow_osc_stable,
  output logic            main_clock_run,
  output logic            cpu_clock_en,
  output logic            peripheral_clock_en,
  output logic            rtc_clock_req,
  output logic            watchdog_async_clock,
  output logic            brownout_async_clock,
  output logic            control_timer_async_clock,
  output logic      [1:0] control_timer_src_eff,
  output logic      [1:0] fast_osc_freq
);
  logic [2:0] key_win_ff;
  logic [1:0] sel_ff;
  logic [1:0] pend_sel_ff;
  logic [4:0] pdiv_ff;
  logic [4:0] pdiv_pend_ff;
  logic [5:0] div_cnt_ff;
  logic       per_en_ff;
  logic [3:0] edge_cnt_ff;
  logic [1:0] ext_start_ff;
  logic [1:0] ext_sync_ff;
  logic [1:0] xtal_sync_ff;
  logic       ext_prev_ff;
  logic       xtal_prev_ff;
  logic       lock_ff;
  logic [1:0] tcd_src_ff;
  logic [1:0] freq_ff;
  logic       rst_seen_ff;
  logic       run_ff;
  clock_controller_pkg::switch_state_t sw_ff;
  logic       unlocked;
  logic       ext_edge;
  logic       pend_is_ext;
  logic       pend_edge;
  logic [3:0] req;
  logic [5:0] div_max;
  logic       div_wrap;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      key_win_ff <= 3'h0;
    end else if (protect_key_we && protect_key_wdata == clock_controller_pkg::PROTECT_KEY) begin
      key_win_ff <= clock_controller_pkg::PROTECT_WINDOW;
    end else if (instr_retired && key_win_ff != 3'h0) begin
      key_win_ff <= key_win_ff - 3'h1;
    end
  end
  assign unlocked = (key_win_ff != 3'h0);

  // pins cross two flops before any edge logic
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_sync_ff  <= 2'h0;
      xtal_sync_ff <= 2'h0;
      ext_prev_ff  <= 1'b0;
      xtal_prev_ff <= 1'b0;
    end else begin
      ext_sync_ff  <= {ext_sync_ff[0], ext_pin_clock};
      xtal_sync_ff <= {xtal_sync_ff[0], crystal_32k_clock};
      ext_prev_ff  <= ext_sync_ff[1];
      xtal_prev_ff <= xtal_sync_ff[1];
    end
  end
  assign ext_edge = (pend_sel_ff == clock_controller_pkg::SRC_EXT_PIN)
                    ? (ext_sync_ff[1] && !ext_prev_ff)
                    : (xtal_sync_ff[1] && !xtal_prev_ff);
  assign pend_is_ext = (pend_sel_ff == clock_controller_pkg::SRC_EXT_PIN) ||
                       (pend_sel_ff == clock_controller_pkg::SRC_CRYSTAL_32K);
  assign pend_edge = ext_edge && (edge_cnt_ff != clock_controller_pkg::EDGE_THRESHOLD);

  // source switch sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_ff      <= clock_controller_pkg::SRC_RESET;
      pend_sel_ff <= clock_controller_pkg::SRC_RESET;
      edge_cnt_ff <= 4'h0;
      lock_ff     <= 1'b0;
      sw_ff       <= clock_controller_pkg::SW_IDLE;
    end else begin
      case (sw_ff)
        clock_controller_pkg::SW_IDLE: begin
          // write needs open window; lock refuses
          if (ctrl_a_we && unlocked && !lock_ff && ctrl_a_wdata != sel_ff) begin
            pend_sel_ff <= ctrl_a_wdata;
            edge_cnt_ff <= 4'h0;
            sw_ff       <= clock_controller_pkg::SW_WAIT;
          end
        end
        clock_controller_pkg::SW_WAIT: begin
          if (!pend_is_ext) begin
            sw_ff <= clock_controller_pkg::SW_CHANGE;
          end else begin
            lock_ff <= 1'b1;
            if (pend_edge) begin
              edge_cnt_ff <= edge_cnt_ff + 4'h1;
            end
            if (edge_cnt_ff == clock_controller_pkg::EDGE_THRESHOLD &&
                (pend_sel_ff != clock_controller_pkg::SRC_CRYSTAL_32K || crystal_32k_enable)) begin
              sw_ff <= clock_controller_pkg::SW_CHANGE;
            end
          end
        end
        clock_controller_pkg::SW_CHANGE: begin
          // change only at a prescaler wrap
          if (div_wrap) begin
            sel_ff  <= pend_sel_ff;
            lock_ff <= 1'b0;
            sw_ff   <= clock_controller_pkg::SW_IDLE;
          end
        end
        default: sw_ff <= clock_controller_pkg::SW_IDLE;
      endcase
    end
  end
  assign source_switch_pending = (sw_ff != clock_controller_pkg::SW_IDLE);
  assign main_source_select    = sel_ff;

  // prescaler, bit0 enables division, bits 4:1 pick the factor
  always_comb begin
    case (pdiv_ff[4:1])
      4'h0: div_max = 6'h01;
      4'h1: div_max = 6'h03;
      4'h2: div_max = 6'h07;
      4'h3: div_max = 6'h0F;
      4'h4: div_max = 6'h1F;
      4'h5: div_max = 6'h3F;
      4'h8: div_max = 6'h05;
      4'h9: div_max = 6'h09;
      4'hA: div_max = 6'h0B;
      4'hB: div_max = 6'h17;
      4'hC: div_max = 6'h2F;
      default: div_max = 6'h01;
    endcase
    if (!pdiv_ff[0]) begin
      div_max = 6'h00;
    end
  end
  assign div_wrap = (div_cnt_ff == div_max);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pdiv_ff      <= {clock_controller_pkg::PDIV_RESET, 1'b1};
      pdiv_pend_ff <= {clock_controller_pkg::PDIV_RESET, 1'b1};
      div_cnt_ff   <= 6'h00;
      per_en_ff    <= 1'b0;
    end else begin
      if (ctrl_b_we && unlocked) begin
        pdiv_pend_ff <= ctrl_b_wdata;
      end
      // new factor loads at wrap or while the main clock is stopped
      if (div_wrap || !run_ff) begin
        div_cnt_ff <= 6'h00;
        pdiv_ff    <= pdiv_pend_ff;
      end else begin
        div_cnt_ff <= div_cnt_ff + 6'h01;
      end
      per_en_ff <= div_wrap && run_ff;
    end
  end
  assign main_clock_control_b = pdiv_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_start_ff <= 2'h0;
    end else if (!req[clock_controller_pkg::SRC_EXT_PIN]) begin
      ext_start_ff <= 2'h0;
    end else if (ext_start_ff != clock_controller_pkg::EXT_START_CYC) begin
      ext_start_ff <= ext_start_ff + 2'h1;
    end
  end

  // main clock running condition; hold for nvm in power down
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      run_ff <= 1'b1;
    end else begin
      case (sleep_mode)
        clock_controller_pkg::MODE_ACTIVE,
        clock_controller_pkg::MODE_IDLE:    run_ff <= 1'b1;
        clock_controller_pkg::MODE_STANDBY: run_ff <= periph_main_req || run_in_standby[sel_ff];
        default:                            run_ff <= nvm_busy;
      endcase
    end
  end
  assign main_clock_run = run_ff;
  assign cpu_clock_en        = run_ff;
  assign peripheral_clock_en = per_en_ff;

  assign rtc_clock_req             = rtc_enabled;
  assign watchdog_async_clock      = wdt_enabled;
  assign brownout_async_clock      = bod_sampled_enabled;
  assign control_timer_async_clock = control_timer_enabled;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tcd_src_ff <= clock_controller_pkg::SRC_RESET;
    end else if (!control_timer_enabled) begin
      tcd_src_ff <= control_timer_src;
    end
  end
  assign control_timer_src_eff = tcd_src_ff;

  // requests per source; routed by owner
  always_comb begin
    req = 4'h0;
    if (run_ff) begin
      req[sel_ff] = 1'b1;
    end
    if (source_switch_pending) begin
      req[pend_sel_ff] = 1'b1;
    end
    if (rtc_enabled) begin
      req[rtc_src_crystal ? clock_controller_pkg::SRC_CRYSTAL_32K
                          : clock_controller_pkg::SRC_SLOW_OSC] = 1'b1;
    end
    if (wdt_enabled || bod_sampled_enabled) begin
      req[clock_controller_pkg::SRC_SLOW_OSC] = 1'b1;
    end
    if (control_timer_enabled) begin
      req[tcd_src_ff] = 1'b1;
    end
  end

  // unused oscillators off; standby bit keeps them on except in power down
  always_comb begin
    osc_enable = req;
    if (sleep_mode != clock_controller_pkg::MODE_POWER_DOWN) begin
      osc_enable = req | run_in_standby;
    end
    if (!crystal_32k_enable) begin
      osc_enable[clock_controller_pkg::SRC_CRYSTAL_32K] = 1'b0;
    end
  end

  assign ext_pin_clock_stable = (ext_start_ff == clock_controller_pkg::EXT_START_CYC);
  assign crystal_32k_stable   = crystal_32k_ready && crystal_32k_enable;
  assign fast_osc_stable      = fast_osc_ready;
  assign slow_osc_stable      = slow_osc_ready;

  // fuse frequency captured after reset release
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_seen_ff <= 1'b0;
      freq_ff     <= clock_controller_pkg::FREQ_20MHZ;
    end else if (!rst_seen_ff) begin
      rst_seen_ff <= 1'b1;
      freq_ff     <= fast_osc_freq_select;
    end
  end
  assign fast_osc_freq = freq_ff;
endmodule

/* rtl/clock_controller_pkg.sv */
// constants for the main clock select and prescale block
// assumes a single system clock; oscillators and requesters are plain ports
package clock_controller_pkg;
  // main source select encoding
  localparam logic [1:0] SRC_FAST_OSC    = 2'h0;
  localparam logic [1:0] SRC_SLOW_OSC    = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL_32K = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN     = 2'h3;
  localparam logic [1:0] SRC_RESET       = SRC_FAST_OSC;
  // prescaler: enable bit plus 4-bit select, 12 settings
  localparam logic [3:0] PDIV_RESET      = 4'h8;
  localparam int         PDIV_SETTINGS   = 12;
  // protection key and window length in instructions
  localparam logic [7:0] PROTECT_KEY     = 8'hD8;
  localparam logic [2:0] PROTECT_WINDOW  = 3'h4;
  // edges of an external source needed before a switch
  localparam logic [3:0] EDGE_THRESHOLD  = 4'h8;
  // external pin clock start-up in cycles
  localparam logic [1:0] EXT_START_CYC   = 2'h2;
  // sleep modes
  localparam logic [1:0] MODE_ACTIVE     = 2'h0;
  localparam logic [1:0] MODE_IDLE       = 2'h1;
  localparam logic [1:0] MODE_STANDBY    = 2'h2;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
  // fuse frequency select
  localparam logic [1:0] FREQ_16MHZ      = 2'h1;
  localparam logic [1:0] FREQ_20MHZ      = 2'h2;
  typedef enum logic [1:0] {
    SW_IDLE    = 2'b00,
    SW_WAIT    = 2'b01,
    SW_CHANGE  = 2'b11
  } switch_state_t;
endpackage

/* verification/main_clock_select_prescale_assertions.sv */
// checker for the main clock select and prescale block
// assumes it is bound to the block and sees only its ports
module main_clock_select_prescale_assertions (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [1:0] sleep_mode,
  input wire logic       nvm_busy,
  input wire logic       wdt_enabled,
  input wire logic       control_timer_enabled,
  input wire logic       crystal_32k_enable,
  input wire logic [1:0] main_source_select,
  input wire logic [4:0] main_clock_control_b,
  input wire logic       source_switch_pending,
  input wire logic       ext_pin_clock_stable,
  input wire logic       main_clock_run,
  input wire logic       cpu_clock_en,
  input wire logic       watchdog_async_clock,
  input wire logic       control_timer_async_clock,
  input wire logic [1:0] control_timer_src_eff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  chk_reset_state: assert property (disable iff (1'b0)
    srst |=> main_source_select == 2'h0 && main_clock_control_b == 5'h11)
    else $error("reset state wrong");
  chk_cpu_follows: assert property (cpu_clock_en == main_clock_run)
    else $error("cpu clock differs from main clock");
  chk_wdt_request: assert property (watchdog_async_clock == wdt_enabled)
    else $error("watchdog clock request wrong");
  chk_tcd_request: assert property (control_timer_async_clock == control_timer_enabled)
    else $error("control timer clock request wrong");
  chk_awake_runs: assert property ((sleep_mode < 2'h2) [*2] |-> main_clock_run)
    else $error("main clock stopped while awake");
  chk_nvm_holds: assert property (sleep_mode == 2'h3 && nvm_busy |=> main_clock_run)
    else $error("main clock stopped with nvm busy");
  chk_tcd_frozen: assert property (control_timer_enabled |=> $stable(control_timer_src_eff))
    else $error("timer source moved while enabled");
  chk_ext_edges: assert property ($changed(main_source_select) && main_source_select == 2'h3
    |-> $past(ext_pin_clock_stable))
    else $error("switch to pin clock before stable");
  chk_pending_first: assert property ($changed(main_source_select) && !$past(srst)
    |-> $past(source_switch_pending))
    else $error("source changed without pending flag");
  chk_crystal_enable: assert property ($changed(main_source_select) && main_source_select == 2'h2
    |-> crystal_32k_enable)
    else $error("crystal selected while disabled");
endmodule
bind main_clock_select_prescale main_clock_select_prescale_assertions u_chk (.*);

/* verification/osc_partner.sv */
// oscillator and pin clock model facing the clock block
// assumes osc_enable from the block and a run switch from the bench
module osc_partner (
  input  wire logic       clk_sys,
  input  wire logic [3:0] osc_enable,
  input  wire logic       ext_run,
  output logic            ext_pin_clock,
  output logic            crystal_32k_clock,
  output logic            fast_osc_ready,
  output logic            slow_osc_ready,
  output logic            crystal_32k_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] on_d1 = 4'h0;
  logic [3:0] on_d2 = 4'h0;
  int         n     = 0;
  initial begin
    ext_pin_clock = 1'b0;
    crystal_32k_clock = 1'b0;
  end
  // ready only while the block keeps a source on
  assign fast_osc_ready = on_d2[0];
  assign slow_osc_ready = on_d2[1];
  assign crystal_32k_ready = on_d2[2];
  always @(posedge clk_sys) begin
    n <= n + 1;
    on_d1 <= osc_enable;
    on_d2 <= on_d1;
    // pin clock stands still when the bench stalls it
    if (ext_run && n % 3 == 0) ext_pin_clock <= ~ext_pin_clock;
    // crystal swings only when switched on
    if (osc_enable[2] && n % 5 == 0) crystal_32k_clock <= ~crystal_32k_clock;
  end
endmodule

/* verification/test_main_clock_select_prescale.sv */
// bench for the main clock select and prescale block
// assumes the oscillator model and the bound checker
module test_main_clock_select_prescale;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 0;
  logic       srst = 1;
  logic [7:0] protect_key_wdata = 8'h00;
  logic       protect_key_we = 0, instr_retired = 0, ctrl_a_we = 0, ctrl_b_we = 0;
  logic [1:0] ctrl_a_wdata = 2'h0, fast_osc_freq_select = 2'h1;
  logic [1:0] sleep_mode = 2'h0, control_timer_src = 2'h0;
  logic [4:0] ctrl_b_wdata = 5'h00;
  logic [3:0] run_in_standby = 4'h0;
  logic       crystal_32k_enable = 0, nvm_busy = 0, periph_main_req = 0, ext_run = 0;
  logic       rtc_enabled = 0, rtc_src_crystal = 0, wdt_enabled = 0;
  logic       bod_sampled_enabled = 0, control_timer_enabled = 0;
  logic [1:0] main_source_select, control_timer_src_eff, fast_osc_freq;
  logic [4:0] main_clock_control_b;
  logic [3:0] osc_enable;
  logic       source_switch_pending, ext_pin_clock_stable, crystal_32k_stable;
  logic       fast_osc_stable, slow_osc_stable, main_clock_run, cpu_clock_en;
  logic       peripheral_clock_en, rtc_clock_req, watchdog_async_clock;
  logic       brownout_async_clock, control_timer_async_clock;
  logic       ext_pin_clock, crystal_32k_clock, crystal_32k_ready;
  logic       fast_osc_ready, slow_osc_ready;
  int         mismatches = 0;
  int         compares = 0;
  int         cycles = 0;
  logic [5:0] cnt;
  // prescaler settings and pulses expected in 48 cycles
  logic [4:0] cb[9] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h07, 5'h11, 5'h15, 5'h17, 5'h19};
  logic [5:0] np[9] = '{6'h30, 6'h18, 6'h0C, 6'h06, 6'h03, 6'h08, 6'h04, 6'h02, 6'h01};
  main_clock_select_prescale uut (.*);
  osc_partner osc (.*);
  always #2 clk_sys = ~clk_sys;
  task automatic test_done;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ceiling well above the roughly one thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rst;
    @(posedge clk_sys);
    srst <= 1;
    repeat (3) @(posedge clk_sys);
    srst <= 0;
  endtask
  // key, then n retired instructions, then one protected write
  task automatic pw(input logic a, input logic [4:0] d, input int n);
    @(posedge clk_sys);
    protect_key_we <= 1;
    protect_key_wdata <= clock_controller_pkg::PROTECT_KEY;
    repeat (n) begin
      @(posedge clk_sys);
      protect_key_we <= 0;
      instr_retired <= 1;
    end
    @(posedge clk_sys);
    protect_key_we <= 0;
    instr_retired <= 0;
    ctrl_a_we <= a;
    ctrl_b_we <= !a;
    ctrl_a_wdata <= d[1:0];
    ctrl_b_wdata <= d;
    @(posedge clk_sys);
    ctrl_a_we <= 0;
    ctrl_b_we <= 0;
  endtask
  task automatic wsel(input logic [1:0] s);
    for (int k = 0; k < 600 && main_source_select !== s; k++) settle(1);
    chk("select", 6'(s), 6'(main_source_select));
  endtask
  initial begin
    rst;
    settle(2);
    chk("select", 6'h00, 6'(main_source_select));
    chk("ctrl_b", 6'h11, 6'(main_clock_control_b));
    chk("freq", 6'h01, 6'(fast_osc_freq));
    chk("osc_stable", 6'h02, 6'({fast_osc_stable, slow_osc_stable}));
    pw(0, 5'h01, 5);
    settle(60);
    chk("ctrl_b", 6'h11, 6'(main_clock_control_b));
    foreach (cb[i]) begin
      pw(0, cb[i], 3);
      for (int k = 0; k < 100 && main_clock_control_b !== cb[i]; k++) settle(1);
      chk("ctrl_b", 6'(cb[i]), 6'(main_clock_control_b));
      cnt = 6'h00;
      repeat (48) begin
        settle(1);
        cnt += 6'(peripheral_clock_en);
      end
      chk("per_pulses", np[i], cnt);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      {rtc_enabled, wdt_enabled, bod_sampled_enabled, control_timer_enabled} <= 4'(i);
      #1;
      chk("async", 6'(i), 6'({rtc_clock_req, watchdog_async_clock, brownout_async_clock,
          control_timer_async_clock}));
    end
    @(posedge clk_sys);
    control_timer_src <= 2'h1;
    settle(3);
    chk("tcd_src", 6'h00, 6'(control_timer_src_eff));
    @(posedge clk_sys);
    {rtc_enabled, wdt_enabled, bod_sampled_enabled, control_timer_enabled} <= 4'h0;
    settle(3);
    chk("tcd_src", 6'h01, 6'(control_timer_src_eff));
    // rtc request routed to slow oscillator, then to crystal
    @(posedge clk_sys);
    rtc_enabled <= 1;
    #1;
    chk("osc_req", 6'h03, 6'(osc_enable));
    @(posedge clk_sys);
    rtc_src_crystal <= 1;
    crystal_32k_enable <= 1;
    #1;
    chk("osc_req", 6'h05, 6'(osc_enable));
    @(posedge clk_sys);
    crystal_32k_enable <= 0;
    #1;
    chk("osc_req", 6'h01, 6'(osc_enable));
    @(posedge clk_sys);
    rtc_enabled <= 0;
    rtc_src_crystal <= 0;
    pw(1, 5'h01, 0);
    settle(1);
    chk("pending", 6'h01, 6'(source_switch_pending));
    wsel(2'h1);
    chk("pending", 6'h00, 6'(source_switch_pending));
    chk("osc_off", 6'h00, 6'({osc_enable[3], osc_enable[0]}));
    @(posedge clk_sys);
    sleep_mode <= 2'h2;
    settle(3);
    chk("run", 6'h00, 6'(main_clock_run));
    @(posedge clk_sys);
    periph_main_req <= 1;
    settle(3);
    chk("run", 6'h01, 6'(main_clock_run));
    @(posedge clk_sys);
    periph_main_req <= 0;
    run_in_standby <= 4'h3;
    settle(3);
    chk("run_osc", 6'h03, 6'({main_clock_run, osc_enable[0]}));
    @(posedge clk_sys);
    sleep_mode <= 2'h3;
    nvm_busy <= 1;
    settle(3);
    chk("run_osc", 6'h02, 6'({main_clock_run, osc_enable[0]}));
    @(posedge clk_sys);
    nvm_busy <= 0;
    settle(3);
    chk("run", 6'h00, 6'(main_clock_run));
    @(posedge clk_sys);
    sleep_mode <= 2'h0;
    run_in_standby <= 4'h0;
    pw(1, 5'h03, 0);
    settle(100);
    chk("sel_pend", 6'h03, 6'({source_switch_pending, main_source_select[0]}));
    pw(1, 5'h00, 0);
    settle(100);
    chk("select", 6'h01, 6'(main_source_select));
    rst;
    ext_run <= 1;
    settle(2);
    chk("select", 6'h00, 6'(main_source_select));
    pw(1, 5'h03, 0);
    wsel(2'h3);
    chk("ext_stable", 6'h01, 6'(ext_pin_clock_stable));
    rst;
    crystal_32k_enable <= 1;
    pw(1, 5'h02, 0);
    wsel(2'h2);
    chk("xtal_stable", 6'h01, 6'(crystal_32k_stable));
    test_done;
  end
endmodule
